// ==== logic/ufb_pkg.sv ====
// Package: offsets, fields, reset values and encodings of the frame and baud block
package ufb_pkg;

  // ==========================================================
  // Register byte addresses on APB
  localparam logic [7:0] UFB_ADDR_SHARED = 8'h00;  // Frame format or divisor high
  localparam logic [7:0] UFB_ADDR_DIVLO  = 8'h04;  // Divisor low byte
  localparam logic [7:0] UFB_ADDR_CTRLA  = 8'h08;  // Double speed
  localparam logic [7:0] UFB_ADDR_CTRLB  = 8'h0c;  // Char size top, ninth bits
  localparam logic [7:0] UFB_ADDR_STAT   = 8'h10;  // Parity error, live config

  // ==========================================================
  // Field positions
  localparam int UFB_SEL_BIT  = 7;
  localparam int UFB_MODE_BIT = 6;
  localparam int UFB_PAR_HI   = 5;
  localparam int UFB_PAR_LO   = 4;
  localparam int UFB_STOP_BIT = 3;
  localparam int UFB_CSZ_HI   = 2;
  localparam int UFB_CSZ_LO   = 1;
  localparam int UFB_POL_BIT  = 0;
  localparam int UFB_DIVH_MSB = 3;
  localparam int UFB_U2X_BIT  = 1;
  localparam int UFB_CSZ2_BIT = 2;
  localparam int UFB_RX9_BIT  = 1;
  localparam int UFB_TX9_BIT  = 0;

  // ==========================================================
  // Reset values
  localparam logic [6:0]  UFB_FRAME_RST = 7'h06;  // Async, no parity, 1 stop, 8-bit
  localparam logic [11:0] UFB_DIV_RST   = 12'h000;

  // ==========================================================
  // Encodings
  localparam logic [1:0] UFB_PAR_OFF  = 2'h0;
  localparam logic [1:0] UFB_PAR_EVEN = 2'h2;
  localparam logic [1:0] UFB_PAR_ODD  = 2'h3;
  localparam logic [4:0] UFB_OVS_NORM = 5'h10;   // 16 clocks of divider per bit
  localparam logic [4:0] UFB_OVS_DBL  = 5'h08;   // 8 with double speed

  // Character size code to data bit count, zero for reserved codes
  function automatic logic [3:0] ufb_char_bits(input logic [2:0] code);
    unique case (code)
      3'h0:    ufb_char_bits = 4'h5;
      3'h1:    ufb_char_bits = 4'h6;
      3'h2:    ufb_char_bits = 4'h7;
      3'h3:    ufb_char_bits = 4'h8;
      3'h7:    ufb_char_bits = 4'h9;
      default: ufb_char_bits = 4'h0;
    endcase
  endfunction : ufb_char_bits

endpackage : ufb_pkg

// ==== logic/ufb_prescaler.sv ====
// Baud prescaler: divisor counter and oversample counter giving bit ticks
`timescale 1ns/10ps
module ufb_prescaler
  import ufb_pkg::*;
#(
  parameter int DIV_W = 12
) (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             clk_en,
  // Control
  input  wire logic             reload,
  input  wire logic [DIV_W-1:0] divisor,
  input  wire logic             double_speed,
  input  wire logic             sync_mode,
  // Ticks
  output logic                  prescale_tick,
  output logic                  bit_tick
);

  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic [4:0]       ovs;
    logic             ptick;
    logic             btick;
  } ufb_ps_t;

  ufb_ps_t st_q, st_d;
  logic [4:0] ovs_len;

  // Oversample length; double speed only in async mode
  assign ovs_len = (double_speed && !sync_mode) ? UFB_OVS_DBL : UFB_OVS_NORM;

  // Next state: count down divisor, then oversample
  always_comb begin
    st_d       = st_q;
    st_d.ptick = 1'b0;
    st_d.btick = 1'b0;
    if (reload) begin
      st_d.cnt = divisor;
      st_d.ovs = 5'h00;
    end else if (st_q.cnt == '0) begin
      st_d.cnt   = divisor;
      st_d.ptick = 1'b1;
      if (st_q.ovs >= ovs_len - 5'h01) begin
        st_d.ovs   = 5'h00;
        st_d.btick = 1'b1;
      end else begin
        st_d.ovs = st_q.ovs + 5'h01;
      end
    end else begin
      st_d.cnt = st_q.cnt - 1'b1;
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  assign prescale_tick = st_q.ptick;
  assign bit_tick      = st_q.btick;

endmodule : ufb_prescaler

// ==== logic/ufb_frame_baud.sv ====
// Frame format and baud divisor registers with APB slave and parity helpers
// Summary of operation
// - Shared location: write with bit 7 set lands in the frame register.
// - Reading the frame register returns bit 7 as one.
// - Divisor high reads select bit zero (no such read here; shared reads give frame); write with it zero hits divisor.
// - Mode bit: zero asynchronous, one synchronous on external serial clock.
// - Parity field: 00 off, 01 reserved, 10 even, 11 odd, both directions.
// - Transmitter gets computed parity bit for each frame's data.
// - Receiver parity compared with selected type; mismatch sets parity error flag.
// - Stop select: zero one stop bit, one two stop bits for transmit.
// - Receiver ignores the stop bit count setting.
// - Three-bit size code: 5,6,7,8 or 9 data bits; 100-110 reserved.
// - Sync polarity zero: transmit on rising, sample on falling; one reverses.
// - Divisor is 12 bits: high nibble plus low byte.
// - Writing divisor low reloads the prescaler at once with full value.
// - Double speed divides by 8 not 16, async only.
// - Ninth bits: receive read before low byte, transmit written before.
//
// The implementer's own choices: the address map and the APB slave port.
`timescale 1ns/10ps
module ufb_frame_baud
  import ufb_pkg::*;
#(
  parameter int DIV_W = 12
) (
  // Clock, reset, enable
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  // Shift engine side
  input  wire logic [8:0]  tx_data,
  input  wire logic [8:0]  rx_data,
  input  wire logic        rx_parity_bit,
  input  wire logic        rx_frame_done,
  input  wire logic        rx_ninth_in,
  input  wire logic        rx_buf_read,
  // Configuration out
  output logic             sync_mode_select,
  output logic [1:0]       parity_type_field,
  output logic             stop_count_select,
  output logic [3:0]       char_bits,
  output logic             sync_edge_polarity,
  output logic             tx_change_rising,
  output logic             rx_sample_rising,
  output logic             tx_parity_bit,
  output logic             tx_ninth_bit,
  output logic             parity_error_flag,
  output logic             bit_tick,
  output logic             prescale_tick
);

  // ==========================================================
  // State
  typedef struct packed {
    logic [6:0]       frame;
    logic [DIV_W-1:0] div;
    logic             dbl;
    logic             csz2;
    logic             rx9;
    logic             tx9;
    logic             perr;
    logic             reload;
    logic             ready;
    logic             slverr;
    logic [31:0]      rdata;
    logic             txpar;
    logic             txrise;
    logic             rxrise;
  } ufb_state_t;

  ufb_state_t st_q, st_d;

  // Parity of the valid data bits, odd selects inversion
  function automatic logic ufb_parity(input logic [8:0] data, input logic [3:0] nbits,
                                      input logic odd);
    logic p;
    p = odd;
    for (int i = 0; i < 9; i++) begin
      if (i < int'(nbits)) begin
        p = p ^ data[i];
      end
    end
    ufb_parity = p;
  endfunction : ufb_parity

  logic       access;
  logic       wr;
  logic       rd;
  logic [3:0] nbits;
  logic       par_on;
  logic       par_odd;
  logic       rx_par_exp;
  logic       addr_ok;

  // Decode
  assign access  = psel && penable && !st_q.ready;
  assign wr      = access && pwrite;
  assign rd      = access && !pwrite;
  assign addr_ok = (paddr == UFB_ADDR_SHARED) || (paddr == UFB_ADDR_DIVLO) ||
                   (paddr == UFB_ADDR_CTRLA) || (paddr == UFB_ADDR_CTRLB) ||
                   (paddr == UFB_ADDR_STAT);
  assign nbits   = ufb_char_bits({st_q.csz2, st_q.frame[UFB_CSZ_HI:UFB_CSZ_LO]});
  assign par_on  = st_q.frame[UFB_PAR_HI];
  assign par_odd = st_q.frame[UFB_PAR_LO];
  assign rx_par_exp = ufb_parity(rx_data, nbits, par_odd);

  // ==========================================================
  // Next state
  always_comb begin
    st_d        = st_q;
    st_d.reload = 1'b0;
    st_d.ready  = access;
    st_d.slverr = access && !addr_ok;
    st_d.txpar  = ufb_parity(tx_data, nbits, par_odd);
    // Sync edges; polarity one swaps both
    st_d.txrise = !st_q.frame[UFB_POL_BIT];
    st_d.rxrise = st_q.frame[UFB_POL_BIT];
    if (wr) begin
      unique case (paddr)
        UFB_ADDR_SHARED: begin
          if (pwdata[UFB_SEL_BIT]) begin
            st_d.frame = pwdata[6:0];
          end else begin
            st_d.div[DIV_W-1:8] = pwdata[UFB_DIVH_MSB:0];
          end
        end
        UFB_ADDR_DIVLO: begin
          st_d.div[7:0] = pwdata[7:0];
          st_d.reload   = 1'b1;
        end
        UFB_ADDR_CTRLA: st_d.dbl = pwdata[UFB_U2X_BIT];
        UFB_ADDR_CTRLB: begin
          st_d.csz2 = pwdata[UFB_CSZ2_BIT];
          st_d.tx9  = pwdata[UFB_TX9_BIT];
        end
        default: ;
      endcase
    end
    // Read data; shared location returns frame with select one
    if (rd) begin
      unique case (paddr)
        UFB_ADDR_SHARED: st_d.rdata = {24'h000000, 1'b1, st_q.frame};
        UFB_ADDR_DIVLO:  st_d.rdata = {24'h000000, st_q.div[7:0]};
        UFB_ADDR_CTRLA:  st_d.rdata = {29'h0, st_q.perr, st_q.dbl, 1'b0};
        UFB_ADDR_CTRLB:  st_d.rdata = {29'h0, st_q.csz2, st_q.rx9, st_q.tx9};
        UFB_ADDR_STAT:   st_d.rdata = {12'h000, st_q.div, 3'h0, st_q.perr, nbits};
        default:         st_d.rdata = 32'h0000_0000;
      endcase
    end
    // Divisor high view with select zero at address plus one word is not given;
    // software reads the divisor via the status word instead.
    // Parity error: buffer read clears, new frame loads its parity check result (frame wins)
    if (rx_buf_read) begin
      st_d.perr = 1'b0;
    end
    if (rx_frame_done) begin
      st_d.perr = par_on && (rx_parity_bit != rx_par_exp);
      st_d.rx9  = rx_ninth_in;
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q        <= '0;
      st_q.frame  <= UFB_FRAME_RST;
      st_q.div    <= UFB_DIV_RST;
      st_q.txrise <= 1'b1;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  // ==========================================================
  // Prescaler
  logic ps_bit;
  logic ps_pre;

  ufb_prescaler #(
    .DIV_W (DIV_W)
  ) u_prescaler (
    .pclk          (pclk),
    .presetn       (presetn),
    .clk_en        (clk_en),
    .reload        (st_q.reload),
    .divisor       (st_q.div),
    .double_speed  (st_q.dbl),
    .sync_mode     (st_q.frame[UFB_MODE_BIT]),
    .prescale_tick (ps_pre),
    .bit_tick      (ps_bit)
  );

  // ==========================================================
  // Outputs from flip-flops except char_bits, decoded from them; stop count only feeds transmitter
  assign sync_mode_select   = st_q.frame[UFB_MODE_BIT];
  assign parity_type_field  = st_q.frame[UFB_PAR_HI:UFB_PAR_LO];
  assign stop_count_select  = st_q.frame[UFB_STOP_BIT];
  assign sync_edge_polarity = st_q.frame[UFB_POL_BIT];
  assign char_bits          = nbits;
  assign tx_change_rising   = st_q.txrise;
  assign rx_sample_rising   = st_q.rxrise;
  assign tx_parity_bit      = st_q.txpar;
  assign tx_ninth_bit       = st_q.tx9;
  assign parity_error_flag  = st_q.perr;
  assign bit_tick           = ps_bit;
  assign prescale_tick      = ps_pre;
  assign pready             = st_q.ready;
  assign pslverr            = st_q.slverr;
  assign prdata             = st_q.rdata;

  // ==========================================================
  // Assertions
  frame_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && wr && paddr == UFB_ADDR_SHARED && pwdata[7] && !st_q.ready
    |=> st_q.frame == $past(pwdata[6:0]))
    else $error("frame register not written");

  frame_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && rd && paddr == UFB_ADDR_SHARED |=> prdata[7] == 1'b1)
    else $error("select bit not read as one");

  divhi_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && wr && paddr == UFB_ADDR_SHARED && !pwdata[7]
    |=> st_q.div[11:8] == $past(pwdata[3:0]) && $stable(st_q.frame))
    else $error("divisor high write wrong");

  divlo_reload_a: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && wr && paddr == UFB_ADDR_DIVLO |=> st_q.reload ##1 !st_q.reload || !clk_en)
    else $error("prescaler not reloaded");

  par_err_a: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && rx_frame_done && parity_type_field == UFB_PAR_OFF |=> !parity_error_flag)
    else $error("parity error with parity off");

  sync_edge_a: assert property (@(posedge pclk) disable iff (!presetn)
    tx_change_rising != rx_sample_rising)
    else $error("sync edges not opposite");

  apb_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && psel && penable && !pready |=> pready)
    else $error("apb answer late");

  char_size_a: assert property (@(posedge pclk) disable iff (!presetn)
    {st_q.csz2, st_q.frame[2:1]} == 3'h3 |-> char_bits == 4'h8)
    else $error("char size decode wrong");

endmodule : ufb_frame_baud

// ==== sim/ufb_shift_model.sv ====
// Far-side receive engine model that hands finished frames to the block
`timescale 1ns/10ps
module ufb_shift_model
  import ufb_pkg::*;
(
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Commands from the bench
  input  wire logic       go,
  input  wire logic       bad,
  input  wire logic [8:0] data,
  input  wire logic [1:0] par_type,
  // Received frame towards the block
  output logic [8:0]      rx_data,
  output logic            rx_parity_bit,
  output logic            rx_frame_done,
  output logic            rx_ninth_in
);
  // ==========================================================
  // One-cycle frame delivery, same for any stop count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_data       <= 9'h000;
      rx_parity_bit <= 1'b0;
      rx_frame_done <= 1'b0;
      rx_ninth_in   <= 1'b0;
    end else if (go) begin
      rx_data       <= data;
      rx_ninth_in   <= data[8];
      rx_parity_bit <= (^data[7:0]) ^ par_type[0] ^ bad;
      rx_frame_done <= 1'b1;
    end else begin
      // Lines toggle between frames so stale data never looks valid
      rx_data       <= ~rx_data;
      rx_parity_bit <= ~rx_parity_bit;
      rx_ninth_in   <= ~rx_ninth_in;
      rx_frame_done <= 1'b0;
    end
  end
endmodule : ufb_shift_model

// ==== sim/ufb_frame_baud_tb_top.sv ====
// Self-checking bench for the frame format and baud divisor block
`timescale 1ns/10ps
module ufb_frame_baud_tb_top
  import ufb_pkg::*;
;
  typedef struct packed {logic [7:0] f; logic top; logic [3:0] nb;} ufb_row_t;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        go, bad, rx_buf_read, rx_parity_bit, rx_frame_done, rx_ninth_in;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [8:0]  tx_data, rx_data, mdata;
  logic        sync_mode_select, stop_count_select, sync_edge_polarity;
  logic        tx_change_rising, rx_sample_rising, tx_parity_bit, tx_ninth_bit;
  logic        parity_error_flag, bit_tick, prescale_tick;
  logic [1:0]  parity_type_field;
  logic [3:0]  char_bits;
  int          bad_count, total_checks;
  int          cyc = 0;
  ufb_row_t    rows[7] = '{'{8'h80, 1'b0, 4'h5}, '{8'ha2, 1'b0, 4'h6}, '{8'hbc, 1'b0, 4'h7},
    '{8'h96, 1'b0, 4'h8}, '{8'hc7, 1'b1, 4'h9}, '{8'hc0, 1'b1, 4'h0}, '{8'hc3, 1'b1, 4'h0}};

  ufb_frame_baud ufb_frame_baud_i (.pclk(pclk), .presetn(presetn), .clk_en(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .pslverr(pslverr), .prdata(prdata), .tx_data(tx_data),
    .rx_data(rx_data), .rx_parity_bit(rx_parity_bit), .rx_frame_done(rx_frame_done),
    .rx_ninth_in(rx_ninth_in), .rx_buf_read(rx_buf_read),
    .sync_mode_select(sync_mode_select), .parity_type_field(parity_type_field),
    .stop_count_select(stop_count_select), .char_bits(char_bits),
    .sync_edge_polarity(sync_edge_polarity), .tx_change_rising(tx_change_rising),
    .rx_sample_rising(rx_sample_rising), .tx_parity_bit(tx_parity_bit),
    .tx_ninth_bit(tx_ninth_bit), .parity_error_flag(parity_error_flag),
    .bit_tick(bit_tick), .prescale_tick(prescale_tick));

  ufb_shift_model ufb_shift_model_i (.pclk(pclk), .presetn(presetn), .go(go), .bad(bad),
    .data(mdata), .par_type(parity_type_field), .rx_data(rx_data),
    .rx_parity_bit(rx_parity_bit), .rx_frame_done(rx_frame_done), .rx_ninth_in(rx_ninth_in));

  // ==========================================================
  // Clock and hang guard
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  // ==========================================================
  // Helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // APB transfer; request held until the edge that samples pready high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Cycles between two bit ticks
  task automatic gap(input int exp);
    int n;
    n = 0;
    do @(negedge pclk); while (bit_tick !== 1'b1);
    do begin
      @(negedge pclk);
      n++;
    end while (bit_tick !== 1'b1 && n < 200);
    chk(n, exp);
  endtask : gap
  task automatic pulse_go(input logic b);
    @(posedge pclk);
    bad <= b;
    go  <= 1'b1;
    @(posedge pclk);
    go  <= 1'b0;
    repeat (3) @(negedge pclk);
  endtask : pulse_go
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish

  // ==========================================================
  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, go, bad, rx_buf_read} = '0;
    {paddr, pwdata, tx_data, mdata} = '0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      apb(1'b1, UFB_ADDR_CTRLB, {29'h0, rows[i].top, 1'b0, i[0]});
      apb(1'b1, UFB_ADDR_SHARED, {24'h0, rows[i].f});
      apb(1'b0, UFB_ADDR_SHARED, 32'h0);
      chk(rd, {24'h0, rows[i].f});
      chk(char_bits, rows[i].nb);
      chk(sync_mode_select, rows[i].f[6]);
      chk(parity_type_field, rows[i].f[5:4]);
      chk(stop_count_select, rows[i].f[3]);
      chk({tx_change_rising, rx_sample_rising}, {~rows[i].f[0], rows[i].f[0]});
      chk(tx_ninth_bit, i[0]);
      $display("row %0d done", i);
    end
    // Divisor high shares the frame location
    apb(1'b1, UFB_ADDR_SHARED, 32'h86);
    apb(1'b1, UFB_ADDR_SHARED, 32'h0a);
    apb(1'b0, UFB_ADDR_SHARED, 32'h0);
    chk(rd, 32'h86);
    apb(1'b1, UFB_ADDR_DIVLO, 32'h02);
    apb(1'b0, UFB_ADDR_STAT, 32'h0);
    chk(rd[19:8], 12'ha02);
    apb(1'b1, UFB_ADDR_SHARED, 32'h00);
    apb(1'b1, UFB_ADDR_DIVLO, 32'h02);
    gap(48);
    apb(1'b1, UFB_ADDR_CTRLA, 32'h2);
    gap(24);
    apb(1'b1, UFB_ADDR_CTRLA, 32'h0);
    $display("divisor test done");
    // Transmit and receive parity
    apb(1'b1, UFB_ADDR_SHARED, 32'ha6);
    tx_data <= 9'h0b3;
    repeat (2) @(negedge pclk);
    chk(tx_parity_bit, 1'b1);
    apb(1'b1, UFB_ADDR_SHARED, 32'hb6);
    repeat (2) @(negedge pclk);
    chk(tx_parity_bit, 1'b0);
    mdata <= 9'h0b3;
    pulse_go(1'b0);
    chk(parity_error_flag, 1'b0);
    pulse_go(1'b1);
    chk(parity_error_flag, 1'b1);
    apb(1'b0, UFB_ADDR_CTRLA, 32'h0);
    chk(rd[2], 1'b1);
    rx_buf_read <= 1'b1;
    @(posedge pclk);
    rx_buf_read <= 1'b0;
    repeat (2) @(negedge pclk);
    chk(parity_error_flag, 1'b0);
    $display("parity test done");
    // Unmapped location
    apb(1'b1, 8'h14, 32'hffffffff);
    chk(err, 1'b1);
    apb(1'b0, 8'h14, 32'h0);
    chk({err, rd}, {1'b1, 32'h0});
    $display("unmapped test done");
    // Reset in mid-run
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, UFB_ADDR_SHARED, 32'h0);
    chk(rd, 32'h86);
    apb(1'b0, UFB_ADDR_STAT, 32'h0);
    chk(rd[19:8], 12'h000);
    chk({sync_mode_select, parity_type_field, stop_count_select, char_bits}, 8'h08);
    $display("reset test done");
    tally_and_finish();
  end
endmodule : ufb_frame_baud_tb_top
